// File: verilog/osc_ctrl.v
// oscillator and multiplier-loop control register with an axi4-lite slave
`timescale 1ns/10ps
`default_nettype none
`include "osc_ctrl_defs.vh"

module osc_ctrl #(
   parameter CAL_W = 8
)
(
   input wire aclk,
   input wire aresetn,
   // axi4-lite slave
   input wire [3:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output wire s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output wire s_axi_wready,
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   input wire [3:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output wire s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   // clock manager side
   input wire [CAL_W-1:0] factory_cal,
   input wire internal_osc_ready,
   input wire external_osc_ready,
   input wire multiplier_loop_ready,
   input wire external_osc_failed,
   input wire [1:0] sysclk_source,
   input wire sysclk_switching_to_pll,
   input wire pll_from_internal,
   input wire lowpower_enter,
   input wire lowpower_wake,
   output reg internal_osc_enable,
   output reg [4:0] internal_osc_trim,
   output reg external_osc_enable,
   output reg external_osc_bypass,
   output reg clock_monitor_enable,
   output reg multiplier_loop_enable,
   output reg force_internal_source,
   output wire irq
);

   // ------------------------------------------------------------
   // input synchronisers
   // ------------------------------------------------------------
   // oscillator status arrives from analogue domains: two stages each
   // only the second stage is read anywhere, so a metastable first
   // stage never reaches the register view or the event logic
   // cost: every ready and failure level shows two cycles late,
   // which software never notices behind a polling loop
   // bundled into one vector so all four share identical latency
   // and their relative order of arrival is kept
   reg [3:0] sync1_q;
   reg [3:0] sync2_q;
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         sync1_q <= 4'h0;
         sync2_q <= 4'h0;
      end
      else
      begin
         sync1_q <= {external_osc_failed, multiplier_loop_ready,
                     external_osc_ready, internal_osc_ready};
         sync2_q <= sync1_q;
      end
   end
   wire int_stable = sync2_q[0];
   wire ext_stable = sync2_q[1];
   wire pll_locked = sync2_q[2];
   wire ext_fail = sync2_q[3];

   // ------------------------------------------------------------
   // axi write channel
   // ------------------------------------------------------------
   // address and data may arrive in either order; whichever comes
   // first is parked in a holding register until its partner shows
   // the write fires in the cycle both are present, so a master that
   // offers both together sees zero wait states
   // a pending response blocks both channels: one write in flight
   // unknown offsets still answer, with a slave error, so a stray
   // access never hangs the bus
   reg aw_held_q;
   reg [3:0] aw_addr_q;
   reg w_held_q;
   reg [31:0] w_data_q;
   reg [3:0] w_strb_q;
   // address and data accepted independently, one write in flight
   assign s_axi_awready = !aw_held_q && !s_axi_bvalid;
   assign s_axi_wready = !w_held_q && !s_axi_bvalid;
   wire aw_now = aw_held_q || s_axi_awvalid;
   wire w_now = w_held_q || s_axi_wvalid;
   wire [3:0] wr_addr = aw_held_q ? aw_addr_q : s_axi_awaddr;
   wire [31:0] wr_data = w_held_q ? w_data_q : s_axi_wdata;
   wire [3:0] wr_strb = w_held_q ? w_strb_q : s_axi_wstrb;
   wire wr_fire = aw_now && w_now && !s_axi_bvalid;
   wire wr_ctrl = wr_fire && (wr_addr == `OFS_OSC_CTRL);
   wire wr_stat = wr_fire && (wr_addr == `OFS_EVT_STATUS);
   wire wr_mask = wr_fire && (wr_addr == `OFS_EVT_MASK);
   wire wr_ok = wr_ctrl || wr_stat || wr_mask;

   // byte-lane merge so byte and halfword writes leave other lanes alone
   // each field lives in one lane, so a partial write never splits one
   wire [31:0] wmask;
   genvar g;
   generate
      for (g = 0; g < 4; g = g + 1)
      begin : lane_g
         assign wmask[g*8 +: 8] = {8{wr_strb[g]}};
      end
   endgenerate

   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_held_q <= 1'b0;
         w_held_q <= 1'b0;
         aw_addr_q <= 4'h0;
         w_data_q <= 32'h00000000;
         w_strb_q <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `RESP_OKAY;
      end
      else
      begin
         if (s_axi_awvalid && s_axi_awready && !w_now)
         begin
            aw_held_q <= 1'b1;
            aw_addr_q <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready && !aw_now)
         begin
            w_held_q <= 1'b1;
            w_data_q <= s_axi_wdata;
            w_strb_q <= s_axi_wstrb;
         end
         if (wr_fire)
         begin
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
         end
         else if (s_axi_bready)
            s_axi_bvalid <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // control register
   // ------------------------------------------------------------
   // software writes are merged per lane; read-only bits and the
   // reserved bits are simply never stored
   // a clear of an enable is refused while that source feeds the
   // system clock: the written zero is or-ed with the in-use term
   // hardware events are applied after the software write in the
   // same process, so they win on a collision
   // limitation: the in-use terms trust the source select inputs;
   // a wrong select from outside can strand an enable
   wire [31:0] wv = wr_data & wmask;
   wire [31:0] wk = wmask;
   // sources feeding the system clock, directly or through the loop
   wire pll_in_use = (sysclk_source == `SRC_PLL) || sysclk_switching_to_pll;
   wire int_in_use = (sysclk_source == `SRC_INT) || (pll_in_use && pll_from_internal);
   wire ext_in_use = (sysclk_source == `SRC_EXT) || (pll_in_use && !pll_from_internal);
   // a failure only counts while monitored and feeding the system
   wire css_trip = clock_monitor_enable && ext_fail && ext_in_use;
   reg cal_loaded_q;
   reg [CAL_W-1:0] cal_q;

   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         internal_osc_enable <= `RST_INT_EN;
         internal_osc_trim <= `RST_TRIM;
         external_osc_enable <= 1'b0;
         external_osc_bypass <= 1'b0;
         clock_monitor_enable <= 1'b0;
         multiplier_loop_enable <= 1'b0;
         force_internal_source <= 1'b0;
         cal_loaded_q <= 1'b0;
         cal_q <= {CAL_W{1'b0}};
      end
      else
      begin
         // calibration captured once after reset release, never written by software
         if (!cal_loaded_q)
         begin
            cal_q <= factory_cal;
            cal_loaded_q <= 1'b1;
         end
         force_internal_source <= css_trip;
         if (wr_ctrl)
         begin
            if (wk[`BIT_INT_EN])
               internal_osc_enable <= wv[`BIT_INT_EN] | int_in_use;
            if (wk[`TRIM_LSB])
               internal_osc_trim <= wv[`TRIM_MSB:`TRIM_LSB];
            if (wk[`BIT_EXT_EN])
               external_osc_enable <= wv[`BIT_EXT_EN] | ext_in_use;
            if (wk[`BIT_EXT_BYPASS])
               external_osc_bypass <= wv[`BIT_EXT_BYPASS];
            if (wk[`BIT_MON_EN])
               clock_monitor_enable <= wv[`BIT_MON_EN];
            if (wk[`BIT_PLL_EN])
               multiplier_loop_enable <= wv[`BIT_PLL_EN] | pll_in_use;
         end
         // hardware events override software in the same cycle
         if (lowpower_enter)
         begin
            external_osc_enable <= 1'b0;
            multiplier_loop_enable <= 1'b0;
         end
         if (css_trip)
         begin
            external_osc_enable <= 1'b0;
            if (!pll_from_internal)
               multiplier_loop_enable <= 1'b0;
         end
         if (lowpower_wake || css_trip)
            internal_osc_enable <= 1'b1;
      end
   end

   // ------------------------------------------------------------
   // events and interrupt
   // ------------------------------------------------------------
   // rising edges of the synchronised stable flags and a monitored
   // failure set sticky status bits; write one to clear
   // previous-value flops reset to zero, the idle level of the
   // ready inputs, so no false edge follows reset
   // the interrupt is a plain level of status and mask, both from
   // flops, so it carries no combinational glitch from the bus
   reg [`EVT_W-1:0] evt_status_q;
   reg [`EVT_W-1:0] evt_mask_q;
   reg [2:0] stable_prev_q;
   wire [`EVT_W-1:0] evt_set = {css_trip,
      pll_locked & ~stable_prev_q[2],
      ext_stable & ~stable_prev_q[1],
      int_stable & ~stable_prev_q[0]};
   wire [`EVT_W-1:0] evt_clr = (wr_stat && wk[0]) ? wv[`EVT_W-1:0] : {`EVT_W{1'b0}};
   // set wins over a write-one clear in the same cycle
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         evt_status_q <= {`EVT_W{1'b0}};
         evt_mask_q <= {`EVT_W{1'b0}};
         stable_prev_q <= 3'h0;
      end
      else
      begin
         stable_prev_q <= {pll_locked, ext_stable, int_stable};
         evt_status_q <= (evt_status_q & ~evt_clr) | evt_set;
         if (wr_mask && wk[0])
            evt_mask_q <= wv[`EVT_W-1:0];
      end
   end
   assign irq = |(evt_status_q & evt_mask_q);

   // ------------------------------------------------------------
   // read channel
   // ------------------------------------------------------------
   // the view is rebuilt every cycle from the live fields, so the
   // stable and locked bits follow hardware without a copy
   // read data is registered at the take and then held steady
   // until the master accepts it, even if a field moves meanwhile
   reg [31:0] ctrl_view;
   always @*
   begin
      ctrl_view = 32'h00000000;
      ctrl_view[`BIT_INT_EN] = internal_osc_enable;
      ctrl_view[`BIT_INT_STABLE] = int_stable;
      ctrl_view[`TRIM_MSB:`TRIM_LSB] = internal_osc_trim;
      ctrl_view[`CAL_LSB +: CAL_W] = cal_q;
      ctrl_view[`BIT_EXT_EN] = external_osc_enable;
      ctrl_view[`BIT_EXT_STABLE] = ext_stable;
      ctrl_view[`BIT_EXT_BYPASS] = external_osc_bypass;
      ctrl_view[`BIT_MON_EN] = clock_monitor_enable;
      ctrl_view[`BIT_PLL_EN] = multiplier_loop_enable;
      ctrl_view[`BIT_PLL_LOCKED] = pll_locked;
   end

   // answer one cycle after the address is taken, no wait states
   assign s_axi_arready = !s_axi_rvalid;
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= `RESP_OKAY;
      end
      else if (s_axi_arvalid && s_axi_arready)
      begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= `RESP_OKAY;
         case (s_axi_araddr)
            `OFS_OSC_CTRL: s_axi_rdata <= ctrl_view;
            `OFS_EVT_STATUS: s_axi_rdata <= {28'h0000000, evt_status_q};
            `OFS_EVT_MASK: s_axi_rdata <= {28'h0000000, evt_mask_q};
            default:
            begin
               s_axi_rdata <= 32'h00000000;
               s_axi_rresp <= `RESP_SLVERR;
            end
         endcase
      end
      else if (s_axi_rready)
         s_axi_rvalid <= 1'b0;
   end

endmodule
`default_nettype wire

// File: verilog/osc_ctrl_defs.vh
// offsets, field positions, reset values and codes of the oscillator control block
`ifndef OSC_CTRL_DEFS_VH
`define OSC_CTRL_DEFS_VH
// register byte offsets
`define OFS_OSC_CTRL 4'h0
`define OFS_EVT_STATUS 4'h4
`define OFS_EVT_MASK 4'h8
// field positions in the control register
`define BIT_INT_EN 0
`define BIT_INT_STABLE 1
`define TRIM_LSB 3
`define TRIM_MSB 7
`define CAL_LSB 8
`define CAL_MSB 15
`define BIT_EXT_EN 16
`define BIT_EXT_STABLE 17
`define BIT_EXT_BYPASS 18
`define BIT_MON_EN 19
`define BIT_PLL_EN 24
`define BIT_PLL_LOCKED 25
// reset values: low byte 0x83 is trim 16 with internal enable and stable
`define RST_TRIM 5'h10
`define RST_INT_EN 1'b1
// system clock source codes
`define SRC_INT 2'h0
`define SRC_EXT 2'h1
`define SRC_PLL 2'h2
// event status bits
`define EVT_INT_STABLE 0
`define EVT_EXT_STABLE 1
`define EVT_PLL_LOCKED 2
`define EVT_EXT_FAIL 3
`define EVT_W 4
// axi response codes
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// File: bench/osc_ctrl_monitor.sv
// port-level concurrent checks for the oscillator control block
`timescale 1ns/10ps
`default_nettype none
`include "osc_ctrl_defs.vh"
module osc_ctrl_monitor (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   input wire logic [1:0] sysclk_source,
   input wire logic sysclk_switching_to_pll,
   input wire logic lowpower_enter,
   input wire logic lowpower_wake,
   input wire logic external_osc_failed,
   input wire logic clock_monitor_enable,
   input wire logic internal_osc_enable,
   input wire logic external_osc_enable,
   input wire logic multiplier_loop_enable,
   input wire logic force_internal_source
);
   // ----------
   // relations
   // ----------
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // zero wait: answers one cycle after the take
   wr_answer_a: assert property (
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> s_axi_bvalid)
      else $error("write answer not one cycle after take");
   rd_answer_a: assert property (
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read answer late");
   rd_block_a: assert property (
      s_axi_rvalid |-> !s_axi_arready) else $error("read taken while answer pending");
   // sources feeding the system must survive software clears; low power entry clears external and loop, and wake sets internal
   int_keep_a: assert property (
      internal_osc_enable && sysclk_source == `SRC_INT |=> internal_osc_enable)
      else $error("internal enable dropped while in use");
   ext_keep_a: assert property (
      external_osc_enable && sysclk_source == `SRC_EXT && !lowpower_enter
      && !clock_monitor_enable |=> external_osc_enable) else $error("external enable dropped");
   loop_keep_a: assert property (
      multiplier_loop_enable && (sysclk_source == `SRC_PLL || sysclk_switching_to_pll)
      && !lowpower_enter && !clock_monitor_enable |=> multiplier_loop_enable)
      else $error("loop enable dropped while selected");
   lp_clear_a: assert property (
      lowpower_enter |=> !external_osc_enable && !multiplier_loop_enable)
      else $error("low power entry left a source on");
   wake_set_a: assert property (
      lowpower_wake |=> internal_osc_enable) else $error("wake did not force internal");
   // failure path passes a two-stage synchroniser first
   fail_switch_a: assert property (
      $rose(external_osc_failed) && clock_monitor_enable && sysclk_source == `SRC_EXT
      |-> ##[1:6] (force_internal_source && !external_osc_enable && internal_osc_enable))
      else $error("monitored failure not handled");
endmodule
bind osc_ctrl osc_ctrl_monitor mon_u (.*);
`default_nettype wire

// File: bench/osc_ctrl_tb_top.sv
// self-checking bench for the oscillator control block
`timescale 1ns/10ps
`default_nettype none
`include "osc_ctrl_defs.vh"
`define CHK(nm, exp, got) begin checked++; if ((got) !== (exp)) begin err_count++; \
   $display("wrong value %s expected %h seen %h", nm, exp, got); end end
module osc_ctrl_tb_top;
   logic aclk = 0;
   logic aresetn = 0;
   logic [3:0] s_axi_awaddr = 0, s_axi_araddr = 0, s_axi_wstrb = 4'hF;
   logic [31:0] s_axi_wdata = 0;
   logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_arvalid = 0;
   logic s_axi_bready = 1, s_axi_rready = 1;
   wire logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
   wire logic [1:0] s_axi_bresp, s_axi_rresp;
   wire logic [31:0] s_axi_rdata;
   logic [7:0] factory_cal = 8'hA5;
   logic internal_osc_ready = 0, external_osc_ready = 0, multiplier_loop_ready = 0;
   logic external_osc_failed = 0, sysclk_switching_to_pll = 0, pll_from_internal = 0;
   logic lowpower_enter = 0, lowpower_wake = 0;
   logic [1:0] sysclk_source = 0;
   wire logic internal_osc_enable, external_osc_enable, external_osc_bypass;
   wire logic clock_monitor_enable, multiplier_loop_enable, force_internal_source;
   wire logic [4:0] internal_osc_trim;
   int err_count = 0, checked = 0;
   logic [31:0] rd;
   logic [1:0] rsp;
   osc_ctrl dut_u (.*);
   // ----------
   // bus tasks
   // ----------
   // write with the current s_axi_wstrb; bready stays high, so the answer is taken at once
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      bit aw_t;
      bit w_t;
      begin
         aw_t = 0;
         w_t = 0;
         @(posedge aclk);
         s_axi_awaddr <= a;
         s_axi_wdata <= d;
         s_axi_awvalid <= 1'b1;
         s_axi_wvalid <= 1'b1;
         while (!(aw_t && w_t))
         begin
            @(posedge aclk);
            aw_t = aw_t | s_axi_awready;
            w_t = w_t | s_axi_wready;
            s_axi_awvalid <= !aw_t;
            s_axi_wvalid <= !w_t;
         end
         do @(posedge aclk); while (!s_axi_bvalid);
         rsp = s_axi_bresp;
      end
   endtask
   task automatic rd_reg(input logic [3:0] a);
      begin
         @(posedge aclk);
         s_axi_araddr <= a;
         s_axi_arvalid <= 1'b1;
         do @(posedge aclk); while (!s_axi_arready);
         s_axi_arvalid <= 1'b0;
         do @(posedge aclk); while (!s_axi_rvalid);
         rd = s_axi_rdata;
         rsp = s_axi_rresp;
      end
   endtask
   task automatic rchk(input logic [3:0] a, input logic [31:0] e);
      begin
         rd_reg(a);
         `CHK("register read", e, rd)
      end
   endtask
   task finish_test;
      begin
         $display("checks %0d mismatches %0d", checked, err_count);
         if (err_count == 0 && checked > 0)
            $display("verification passed");
         else
            $display("verification failed");
         $finish;
      end
   endtask
   // ----------
   // sequence
   // ----------
   initial
   begin
      forever #5 aclk = ~aclk;
   end
   // generous bound: the whole sequence needs under a hundred cycles
   initial
   begin
      repeat (5000) @(posedge aclk);
      err_count++;
      finish_test;
   end
   initial
   begin
      repeat (5) @(posedge aclk);
      aresetn <= 1'b1;
      internal_osc_ready <= 1'b1;
      repeat (4) @(posedge aclk);
      rchk(`OFS_OSC_CTRL, 32'h0000A583);
      `CHK("read resp", `RESP_OKAY, rsp)
      wr(`OFS_OSC_CTRL, 32'hFFFFFFFF);
      `CHK("write resp", `RESP_OKAY, rsp)
      rchk(`OFS_OSC_CTRL, 32'h010DA5FB);
      `CHK("trim", 5'h1F, internal_osc_trim)
      `CHK("bypass", 1'b1, external_osc_bypass)
      wr(`OFS_OSC_CTRL, 32'h0);
      rchk(`OFS_OSC_CTRL, 32'h0000A503);
      // byte write to lane 2 only: lane 0 and the loop enable stay put
      s_axi_wstrb <= 4'h4;
      wr(`OFS_OSC_CTRL, 32'hFFFFFFFF);
      s_axi_wstrb <= 4'hF;
      rchk(`OFS_OSC_CTRL, 32'h000DA503);
      wr(`OFS_OSC_CTRL, 32'h01090001);
      `CHK("monitor port", 1'b1, clock_monitor_enable)
      `CHK("loop port", 1'b1, multiplier_loop_enable)
      external_osc_ready <= 1'b1;
      multiplier_loop_ready <= 1'b1;
      repeat (4) @(posedge aclk);
      rchk(`OFS_OSC_CTRL, 32'h030BA503);
      `CHK("masked irq", 1'b0, irq)
      wr(`OFS_EVT_MASK, 32'hF);
      @(posedge aclk);
      `CHK("irq", 1'b1, irq)
      rchk(`OFS_EVT_STATUS, 32'h7);
      wr(`OFS_EVT_STATUS, 32'h7);
      @(posedge aclk);
      `CHK("cleared irq", 1'b0, irq)
      // external in use: software may drop internal but not external
      sysclk_source <= `SRC_EXT;
      wr(`OFS_OSC_CTRL, 32'h0);
      rchk(`OFS_OSC_CTRL, 32'h0203A502);
      lowpower_enter <= 1'b1;
      @(posedge aclk);
      lowpower_enter <= 1'b0;
      lowpower_wake <= 1'b1;
      @(posedge aclk);
      lowpower_wake <= 1'b0;
      @(posedge aclk);
      `CHK("ext enable", 1'b0, external_osc_enable)
      `CHK("int enable", 1'b1, internal_osc_enable)
      sysclk_source <= `SRC_INT;
      sysclk_switching_to_pll <= 1'b1;
      pll_from_internal <= 1'b1;
      wr(`OFS_OSC_CTRL, 32'h01000001);
      wr(`OFS_OSC_CTRL, 32'h0);
      rchk(`OFS_OSC_CTRL, 32'h0302A503);
      sysclk_switching_to_pll <= 1'b0;
      pll_from_internal <= 1'b0;
      sysclk_source <= `SRC_EXT;
      wr(`OFS_OSC_CTRL, 32'h00090001);
      external_osc_failed <= 1'b1;
      repeat (6) @(posedge aclk);
      `CHK("force internal", 1'b1, force_internal_source)
      `CHK("ext after fail", 1'b0, external_osc_enable)
      wr(4'hC, 32'h0);
      `CHK("unmapped write resp", `RESP_SLVERR, rsp)
      rd_reg(4'hC);
      `CHK("unmapped resp", `RESP_SLVERR, rsp)
      `CHK("unmapped data", 32'h0, rd)
      finish_test;
   end
endmodule
`default_nettype wire
